// ===== hw/fevt_ctrl.sv
/*
 * Fault event interrupt controller top: control, data and address
 * registers, held-event tracking, message launch and local interrupt.
 * Assumes status flags from same-clock fault logic and a register
 * master that never issues read and write together.
 */
`timescale 1ns/1ns
`include "fevt_params.svh"
module fevt_ctrl (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  // Register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [31:0]                      reg_rdata,
  // Fault status sources
  input  wire logic [`FEVT_NUM_SLOTS-1:0]  slot_valid,
  input  wire logic                        adv_active,
  input  wire logic                        advanced_log_pending,
  input  wire logic                        queue_error_flag,
  input  wire logic                        completion_error_flag,
  input  wire logic                        timeout_error_flag,
  input  wire logic                        other_flags,
  output logic                             primary_log_pending,
  // Message write to interrupt delivery
  output logic                             msg_valid,
  input  wire logic                        msg_ready,
  output logic [31:0]                      msg_addr,
  output logic [31:0]                      msg_addr_hi,
  output logic [`FEVT_DATA_W-1:0]          msg_data,
  // Local interrupt
  output logic                             irq
);
  // ****************************************************************
  // Internal signals
  // ****************************************************************
  fevt_msg_if mif ();

  logic                    event_mask_q;
  logic                    event_mask_d;
  logic                    event_held_q;
  logic                    event_held_d;
  logic [`FEVT_DATA_W-1:0] event_message_data_q;
  logic [31:2]             event_message_address_q;
  logic [31:0]             addr_hi_q;
  logic [`FEVT_IRQ_W-1:0]  irq_stat_q;
  logic [`FEVT_IRQ_W-1:0]  irq_en_q;
  logic [`FEVT_IRQ_W-1:0]  irq_set;
  logic [`FEVT_IRQ_W-1:0]  irq_clr;
  logic [15:0]             msg_cnt_q;
  logic [31:0]             rdata_d;
  logic                    any_flag;
  logic                    cond;
  logic                    fire;
  logic                    sw_service;
  logic                    wr_ctrl;

  // ****************************************************************
  // Condition detection and message sender
  // ****************************************************************
  fevt_event_detect u_detect (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .ce                    (ce),
    .slot_valid            (slot_valid),
    .adv_active            (adv_active),
    .advanced_log_pending  (advanced_log_pending),
    .queue_error_flag      (queue_error_flag),
    .completion_error_flag (completion_error_flag),
    .timeout_error_flag    (timeout_error_flag),
    .other_flags           (other_flags),
    .primary_log_pending   (primary_log_pending),
    .any_flag              (any_flag),
    .cond                  (cond)
  );

  fevt_msg_sender u_sender (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .mif         (mif.sender),
    .msg_valid   (msg_valid),
    .msg_ready   (msg_ready),
    .msg_addr    (msg_addr),
    .msg_addr_hi (msg_addr_hi),
    .msg_data    (msg_data)
  );

  // ****************************************************************
  // Control register writes
  // ****************************************************************
  assign wr_ctrl = reg_wr && (reg_addr == `FEVT_OFS_CTRL);

  // Next mask used so a same-cycle mask write already blocks launch
  always_comb begin
    event_mask_d = event_mask_q;
    if (wr_ctrl) begin
      event_mask_d = reg_wdata[`FEVT_BIT_MASK];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_mask_q <= `FEVT_RST_MASK;
    end else if (ce) begin
      event_mask_q <= event_mask_d;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_message_data_q <= '0;
    end else if (ce && reg_wr && reg_addr == `FEVT_OFS_DATA) begin
      event_message_data_q <= reg_wdata[`FEVT_DATA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_message_address_q <= '0;
    end else if (ce && reg_wr && reg_addr == `FEVT_OFS_ADDR) begin
      event_message_address_q <= reg_wdata[31:`FEVT_ADDR_LSB];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_hi_q <= '0;
    end else if (ce && reg_wr && reg_addr == `FEVT_OFS_ADDR_HI) begin
      addr_hi_q <= reg_wdata;
    end
  end

  // ****************************************************************
  // Held event and message launch
  // ****************************************************************
  // Busy sender is the transient hold
  assign fire = event_held_q && !event_mask_d && !mif.busy;
  assign sw_service = event_held_q && !any_flag && !fire;

  assign mif.launch  = ce && fire;
  assign mif.addr    = {event_message_address_q, 2'b00};
  assign mif.addr_hi = addr_hi_q;
  assign mif.data    = event_message_data_q;

  // New condition wins over a same-cycle service
  always_comb begin
    event_held_d = event_held_q;
    if (cond) begin
      event_held_d = 1'b1;
    end else if (fire || sw_service) begin
      event_held_d = 1'b0;
    end
  end

  // Held while masked or busy, merging conditions
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_held_q <= `FEVT_RST_HELD;
    end else if (ce) begin
      event_held_q <= event_held_d;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_cnt_q <= '0;
    end else if (ce && mif.sent) begin
      msg_cnt_q <= msg_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Local interrupt status, enable and clear
  // ****************************************************************
  assign irq_set[`FEVT_IRQ_COND]  = cond;
  assign irq_set[`FEVT_IRQ_SENT]  = mif.sent;
  assign irq_set[`FEVT_IRQ_SWSVC] = sw_service;

  assign irq_clr = (reg_wr && reg_addr == `FEVT_OFS_IRQ_CLR)
                   ? reg_wdata[`FEVT_IRQ_W-1:0] : '0;

  // Set wins over clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= '0;
    end else if (ce && reg_wr && reg_addr == `FEVT_OFS_IRQ_EN) begin
      irq_en_q <= reg_wdata[`FEVT_IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Reserved bits read as zero
  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      `FEVT_OFS_CTRL: begin
        rdata_d[`FEVT_BIT_MASK] = event_mask_q;
        rdata_d[`FEVT_BIT_HELD] = event_held_q;
      end
      `FEVT_OFS_DATA: begin
        rdata_d[`FEVT_DATA_W-1:0] = event_message_data_q;
      end
      `FEVT_OFS_ADDR: begin
        rdata_d[31:`FEVT_ADDR_LSB] = event_message_address_q;
      end
      `FEVT_OFS_ADDR_HI: begin
        rdata_d = addr_hi_q;
      end
      `FEVT_OFS_IRQ_STAT: begin
        rdata_d[`FEVT_IRQ_W-1:0] = irq_stat_q;
      end
      `FEVT_OFS_IRQ_EN: begin
        rdata_d[`FEVT_IRQ_W-1:0] = irq_en_q;
      end
      `FEVT_OFS_STATE: begin
        rdata_d[0] = event_held_q;
        rdata_d[1] = event_mask_q;
        rdata_d[2] = any_flag;
        rdata_d[3] = primary_log_pending;
        rdata_d[4] = mif.busy;
      end
      `FEVT_OFS_MSG_CNT: begin
        rdata_d[15:0] = msg_cnt_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rdata_d : '0;
    end
  end
endmodule

// ===== hw/fevt_params.svh
/*
 * Constants of the fault event interrupt controller: offsets, field
 * positions, reset values and sizes.
 * Assumes inclusion by bare name from design and testbench files.
 */
// What this block does
// - Mask bit 31 at zero lets a condition send a data/address message.
// - Mask bit resets to one, so messages start masked.
// - No message is ever launched while the mask bit is one.
// - Read-only held bit 30, reset zero, sets on any interrupt condition.
// - Primary logging: slot recorded and primary pending set is a condition.
// - Advanced logging: record zero written, advanced pending set is a condition.
// - Queue error flag setting is a condition.
// - Completion error flag setting is a condition.
// - Time-out error flag setting is a condition.
// - A flag set while another status flag stands is no new condition.
// - Held bit stays set while mask or transient busy withholds the message.
// - Held bit clears at once when the pending message is serviced.
// - Withheld message goes out when busy ends or mask clears; held clears.
// - Software clearing all status sources also clears the held bit.
// - Message data comes from a 16-bit field of its own register.
// - Message address is bits 31:2 of the address register, word aligned.
// - Primary pending equals the OR of all slot valid flags.
`ifndef FEVT_PARAMS_SVH
`define FEVT_PARAMS_SVH
`define FEVT_OFS_CTRL      8'h38
`define FEVT_OFS_DATA      8'h3C
`define FEVT_OFS_ADDR      8'h40
`define FEVT_OFS_ADDR_HI   8'h44
`define FEVT_OFS_IRQ_STAT  8'h80
`define FEVT_OFS_IRQ_EN    8'h84
`define FEVT_OFS_IRQ_CLR   8'h88
`define FEVT_OFS_STATE     8'h8C
`define FEVT_OFS_MSG_CNT   8'h90
`define FEVT_BIT_MASK      31
`define FEVT_BIT_HELD      30
`define FEVT_RST_MASK      1'b1
`define FEVT_RST_HELD      1'b0
`define FEVT_DATA_W        16
`define FEVT_ADDR_LSB      2
`define FEVT_NUM_SLOTS     8
`define FEVT_NUM_FLAGS     6
`define FEVT_IRQ_W         3
`define FEVT_IRQ_COND      0
`define FEVT_IRQ_SENT      1
`define FEVT_IRQ_SWSVC     2
`endif

// ===== hw/fevt_pkg.sv
/*
 * Types of the fault event interrupt controller.
 * Assumes the params header for widths.
 */
`include "fevt_params.svh"
package fevt_pkg;
  typedef enum logic [0:0] {
    SND_IDLE,
    SND_WAIT
  } fevt_snd_state_t;
  typedef logic [`FEVT_DATA_W-1:0] fevt_data_t;
endpackage

// ===== hw/fevt_msg_if.sv
/*
 * Carrier between the controller and its message sender.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
interface fevt_msg_if;
  logic               launch;
  logic [31:0]        addr;
  logic [31:0]        addr_hi;
  fevt_pkg::fevt_data_t data;
  logic               busy;
  logic               sent;
  modport ctrl   (output launch, output addr, output addr_hi, output data,
                  input busy, input sent);
  modport sender (input launch, input addr, input addr_hi, input data,
                  output busy, output sent);
endinterface

// ===== hw/fevt_event_detect.sv
/*
 * Detects fresh interrupt conditions from the fault status flags.
 * Assumes flags come from logic on the same clock.
 */
`timescale 1ns/1ns
`include "fevt_params.svh"
module fevt_event_detect (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  input  wire logic [`FEVT_NUM_SLOTS-1:0]  slot_valid,
  input  wire logic                        adv_active,
  input  wire logic                        advanced_log_pending,
  input  wire logic                        queue_error_flag,
  input  wire logic                        completion_error_flag,
  input  wire logic                        timeout_error_flag,
  input  wire logic                        other_flags,
  output logic                             primary_log_pending,
  output logic                             any_flag,
  output logic                             cond
);
  logic [`FEVT_NUM_FLAGS-1:0] flags;
  logic [`FEVT_NUM_FLAGS-1:0] flags_q;
  logic [`FEVT_NUM_FLAGS-1:0] qual;

  assign primary_log_pending = |slot_valid;
  assign flags = {primary_log_pending, advanced_log_pending, queue_error_flag,
                  completion_error_flag, timeout_error_flag, other_flags};
  assign any_flag = |flags;
  // Qualifying rising flags per logging mode
  assign qual = {primary_log_pending & ~adv_active,
                 advanced_log_pending & adv_active,
                 queue_error_flag,
                 completion_error_flag,
                 timeout_error_flag,
                 1'b0} & ~flags_q;
  assign cond = (|qual) & ~(|flags_q);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else if (ce) begin
      flags_q <= flags;
    end
  end
endmodule

// ===== hw/fevt_msg_sender.sv
/*
 * Issues one message write per launch and holds it until accepted.
 * Assumes the delivery side answers with msg_ready.
 */
`timescale 1ns/1ns
`include "fevt_params.svh"
module fevt_msg_sender (
  input  wire logic           ref_clk,
  input  wire logic           sys_rst,
  input  wire logic           ce,
  fevt_msg_if.sender          mif,
  output logic                msg_valid,
  input  wire logic           msg_ready,
  output logic [31:0]         msg_addr,
  output logic [31:0]         msg_addr_hi,
  output fevt_pkg::fevt_data_t msg_data
);
  fevt_pkg::fevt_snd_state_t state_q;

  assign mif.busy  = (state_q == fevt_pkg::SND_WAIT);
  assign mif.sent  = msg_valid & msg_ready;
  assign msg_valid = (state_q == fevt_pkg::SND_WAIT);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= fevt_pkg::SND_IDLE;
    end else if (ce) begin
      unique case (state_q)
        fevt_pkg::SND_IDLE: if (mif.launch) state_q <= fevt_pkg::SND_WAIT;
        fevt_pkg::SND_WAIT: if (msg_ready) state_q <= fevt_pkg::SND_IDLE;
      endcase
    end
  end

  // Message words captured at launch
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_addr    <= '0;
      msg_addr_hi <= '0;
      msg_data    <= '0;
    end else if (ce && mif.launch && !mif.busy) begin
      msg_addr    <= mif.addr;
      msg_addr_hi <= mif.addr_hi;
      msg_data    <= mif.data;
    end
  end
endmodule

// ===== testbench/fevt_ctrl_assertions.sv
/*
 * Port-level checker of the fault event interrupt controller.
 * Assumes binding to fevt_ctrl and a register master that writes
 * the message registers only while no message is pending.
 */
`timescale 1ns/1ns
`include "fevt_params.svh"
module fevt_ctrl_assertions (
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  input wire logic                       ce,
  input wire logic [7:0]                 reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  input wire logic [`FEVT_NUM_SLOTS-1:0] slot_valid,
  input wire logic                       adv_active,
  input wire logic                       advanced_log_pending,
  input wire logic                       queue_error_flag,
  input wire logic                       completion_error_flag,
  input wire logic                       timeout_error_flag,
  input wire logic                       other_flags,
  input wire logic                       primary_log_pending,
  input wire logic                       msg_valid,
  input wire logic                       msg_ready,
  input wire logic [31:0]                msg_addr,
  input wire logic [`FEVT_DATA_W-1:0]    msg_data
);
  // ****
  // Shadow registers
  // ****
  logic        mask_q;
  logic        all_q;
  logic [31:0] data_q;
  logic [31:0] addr_q;
  logic        qual;
  assign qual = (adv_active ? advanced_log_pending : |slot_valid) | queue_error_flag
              | completion_error_flag | timeout_error_flag;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= 1'h1;
      all_q  <= 1'h0;
      data_q <= 32'h0;
      addr_q <= 32'h0;
    end else if (ce) begin
      all_q <= |{slot_valid, advanced_log_pending, queue_error_flag,
                 completion_error_flag, timeout_error_flag, other_flags};
      if (reg_wr && reg_addr == `FEVT_OFS_CTRL) mask_q <= reg_wdata[31];
      if (reg_wr && reg_addr == `FEVT_OFS_DATA) data_q <= reg_wdata;
      if (reg_wr && reg_addr == `FEVT_OFS_ADDR) addr_q <= reg_wdata;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_mask_block;
    mask_q && !msg_valid && !(reg_wr && reg_addr == `FEVT_OFS_CTRL) |=> !msg_valid;
  endproperty
  a_mask_block: assert property (p_mask_block)
    else $error("message launched while masked");
  property p_fire;
    ce && !all_q && qual && !mask_q && !msg_valid && !reg_wr |=> ##[0:2] msg_valid;
  endproperty
  a_fire: assert property (p_fire)
    else $error("unmasked condition sent no message");
  property p_fields;
    $rose(msg_valid) |-> msg_addr == {addr_q[31:2], 2'h0} && msg_data == data_q[15:0];
  endproperty
  a_fields: assert property (p_fields)
    else $error("message fields differ from registers");
  property p_stand;
    msg_valid && !msg_ready |=> msg_valid && $stable(msg_data) && $stable(msg_addr);
  endproperty
  a_stand: assert property (p_stand)
    else $error("message dropped or changed before acceptance");
  property p_one; msg_valid && msg_ready |=> !msg_valid; endproperty
  a_one: assert property (p_one)
    else $error("message repeated after acceptance");
  property p_ctl_read;
    reg_rd && reg_addr == `FEVT_OFS_CTRL |=>
      reg_rdata[31] == $past(mask_q) && reg_rdata[29:0] == 30'h0;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read wrong");
  property p_prim; primary_log_pending == |slot_valid; endproperty
  a_prim: assert property (p_prim)
    else $error("primary pending not OR of slots");
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
endmodule

// ===== testbench/fevt_delivery_model.sv
/*
 * Interrupt delivery side: accepts message writes promptly or late.
 * Assumes one clock shared with the controller.
 */
`timescale 1ns/1ns
module fevt_delivery_model (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        slow,
  input wire logic        msg_valid,
  input wire logic [31:0] msg_addr,
  input wire logic [15:0] msg_data,
  output logic            msg_ready,
  output logic [31:0]     got_cnt,
  output logic [31:0]     got_addr,
  output logic [15:0]     got_data
);
  logic [3:0] wait_q;
  // Ready only after a wait while a message stands
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_ready <= 1'h0;
      wait_q    <= 4'h0;
      got_cnt   <= 32'h0;
      got_addr  <= 32'h0;
      got_data  <= 16'h0;
    end else if (msg_valid && msg_ready) begin
      msg_ready <= 1'h0;
      got_cnt   <= got_cnt + 32'h1;
      got_addr  <= msg_addr;
      got_data  <= msg_data;
      wait_q    <= slow ? 4'(4 + $urandom % 8) : 4'h0;
    end else if (msg_valid) begin
      if (wait_q == 4'h0) msg_ready <= 1'h1;
      else wait_q <= wait_q - 4'h1;
    end
  end
endmodule

// ===== testbench/tb.sv
/*
 * Self-checking bench of the fault event interrupt controller.
 * Assumes the delivery model and the checker beside the design.
 */
`timescale 1ns/1ns
`include "fevt_params.svh"
module tb;
  logic        ref_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic [7:0]  slot_valid = 8'h0;
  logic        adv_active = 1'h0;
  logic        adv_pend = 1'h0;
  logic [2:0]  err = 3'h0;
  logic        other = 1'h0;
  logic        prim, msg_valid, msg_ready, irq, slow = 1'h0;
  logic [31:0] msg_addr, got_cnt, got_addr, v, dv, av;
  logic [15:0] msg_data, got_data;
  int          mismatches = 0, checks_done = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  fevt_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'h1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slot_valid(slot_valid), .adv_active(adv_active), .advanced_log_pending(adv_pend),
    .queue_error_flag(err[0]), .completion_error_flag(err[1]),
    .timeout_error_flag(err[2]), .other_flags(other), .primary_log_pending(prim),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_addr(msg_addr),
    .msg_addr_hi(), .msg_data(msg_data), .irq(irq));
  fevt_delivery_model u_dlv (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
    .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data),
    .msg_ready(msg_ready), .got_cnt(got_cnt), .got_addr(got_addr), .got_data(got_data));
  // ****
  // Tasks
  // ****
  function automatic logic [31:0] ctl(input logic m, input logic h);
    return {m, h, 30'h0};
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic trig(input int k);
    @(posedge ref_clk);
    adv_active <= (k == 1);
    if (k == 0) slot_valid <= 8'(1 << ($urandom % 8));
    if (k == 1) adv_pend <= 1'h1;
    if (k > 1) err <= 3'(1 << (k - 2));
  endtask
  task automatic clr_flags;
    @(posedge ref_clk);
    slot_valid <= 8'h0;
    adv_pend   <= 1'h0;
    err        <= 3'h0;
    other      <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wait_msg(input logic [31:0] n);
    for (int i = 0; i < 60 && got_cnt !== n; i++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(32'h9B96));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(8'h38, v); chk(v, ctl(1'h1, 1'h0));
    rd(8'h20, v); chk(v, 32'h0);
    dv = $urandom;
    av = $urandom;
    wr(8'h3C, dv);
    wr(8'h40, av);
    rd(8'h3C, v); chk(v, {16'h0, dv[15:0]});
    rd(8'h40, v); chk(v, {av[31:2], 2'h0});
    wr(8'h84, 32'h7);
    trig(2);
    rd(8'h38, v); chk(v, ctl(1'h1, 1'h1));
    clr_flags();
    trig(3);
    repeat (8) @(posedge ref_clk);
    chk(got_cnt, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h38, v); wr(8'h38, v & 32'h7FFF_FFFF);
    wait_msg(32'h1); chk(got_cnt, 32'h1);
    chk({16'h0, got_data}, {16'h0, dv[15:0]});
    chk(got_addr, {av[31:2], 2'h0});
    rd(8'h38, v); chk(v, ctl(1'h0, 1'h0));
    clr_flags();
    wr(8'h84, 32'h0);
    wr(8'h88, 32'h7);
    rd(8'h80, v); chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (int k = 0; k < 5; k++) begin
      slow <= k[0];
      dv = $urandom;
      wr(8'h3C, dv);
      trig(k);
      wait_msg(32'(k + 2)); chk(got_cnt, 32'(k + 2));
      chk({16'h0, got_data}, {16'h0, dv[15:0]});
      chk({31'h0, prim}, {31'h0, k == 0});
      clr_flags();
    end
    other <= 1'h1;
    trig(4);
    wait_msg(32'h7); chk(got_cnt, 32'h6);
    clr_flags();
    slow <= 1'h1;
    trig(2);
    wait (msg_valid === 1'h1);
    clr_flags();
    trig(3);
    wait_msg(32'h8); chk(got_cnt, 32'h8);
    clr_flags();
    wr(8'h38, 32'h8000_0000);
    trig(0);
    rd(8'h38, v); chk(v, ctl(1'h1, 1'h1));
    clr_flags();
    rd(8'h38, v); chk(v, ctl(1'h1, 1'h0));
    wr(8'h38, 32'h0);
    wait_msg(32'h9); chk(got_cnt, 32'h8);
    tally_and_finish();
  end
endmodule
bind fevt_ctrl fevt_ctrl_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .slot_valid(slot_valid), .adv_active(adv_active),
  .advanced_log_pending(advanced_log_pending), .queue_error_flag(queue_error_flag),
  .completion_error_flag(completion_error_flag), .timeout_error_flag(timeout_error_flag),
  .other_flags(other_flags), .primary_log_pending(primary_log_pending),
  .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_addr(msg_addr), .msg_data(msg_data));
